/* verilog/acw_top.sv */
// Calibration coefficient access and converter-0 window comparator
// Summary of operation
// RULE_01 - Offset coefficient 14 bits, 0x2000 is neutral
// RULE_02 - Gain coefficient 13 bits, 0x1000 is neutral
// RULE_03 - Pointer bit 7 advances location after access
// RULE_04 - Pointer bit 6 picks converter coefficient bank
// RULE_05 - Pointer bits 5-0 address coefficient location
// RULE_06 - Data port reads and writes pointed byte
// RULE_07 - Linearity 0x00-0x12, offset 0x13-14, gain 0x15-16
// RULE_08 - Every converter-0 result checked against limits
// RULE_09 - Window flag serves interrupt and polled status
// RULE_10 - Limits held as high and low bytes
// RULE_11 - Compare uses converter-0 data register word
// RULE_12 - Limit ordering selects inside or outside window
// RULE_13 - Lower above upper: flag strictly inside window
// RULE_14 - Upper above lower: flag strictly outside window
// RULE_15 - Differential mode compares signed two's complement
// RULE_16 - Flag set by hardware, cleared by software
module acw_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    input  wire logic        CONV0_DONE,
    input  wire logic [15:0] CONV0_RESULT,
    input  wire logic        DIFF_MODE,
    output logic             WINDOW_FLAG,
    output logic             WINDOW_IRQ,
    output logic [13:0]      OFFSET_COEF0,
    output logic [13:0]      OFFSET_COEF1,
    output logic [12:0]      GAIN_COEF0,
    output logic [12:0]      GAIN_COEF1,
    output logic [13:0]      OFFSET_SHIFT0,
    output logic [13:0]      OFFSET_SHIFT1,
    output logic [12:0]      SLOPE_SHIFT0,
    output logic [12:0]      SLOPE_SHIFT1
);
    typedef struct packed {
        logic        pointer_auto_advance;
        logic        converter_coeff_select;
        logic [5:0]  coefficient_location_pointer;
        logic [15:0] lower_limit;
        logic [15:0] upper_limit;
        logic        window_compare_flag;
        logic [7:0]  rdata;
        logic [1:0][13:0] offset_coef;
        logic [1:0][12:0] gain_coef;
        logic [1:0][13:0] offset_shift;
        logic [1:0][12:0] slope_shift;
    } acw_state_s;

    acw_state_s st;
    acw_state_s next_st;

    logic [7:0]       store_rdata;
    logic [1:0][13:0] store_offset;
    logic [1:0][12:0] store_gain;
    logic             hit_pointer;
    logic             hit_port;
    logic             port_wr;
    logic             port_access;
    logic [15:0]      res_key;
    logic [15:0]      lower_key;
    logic [15:0]      upper_key;
    logic             below_lower;
    logic             above_upper;
    logic             inside_mode;
    logic             window_hit;
    logic [1:0][13:0] trim_offset;
    logic [1:0][12:0] trim_slope;

    assign hit_pointer = (SFR_ADDR == acw_pkg::ADDR_CALIB_POINTER);
    assign hit_port    = (SFR_ADDR == acw_pkg::ADDR_CALIB_COEFFICIENT_PORT);
    assign port_wr     = SFR_WR && hit_port;
    assign port_access = (SFR_WR || SFR_RD) && hit_port;

    acw_coef_store #(
        .DEPTH (64),
        .BANKS (2)
    ) u_store (
        .clk         (CLK),
        .wr_en       (port_wr),
        .bank        (st.converter_coeff_select), // [RULE_04]
        .loc         (st.coefficient_location_pointer), // [RULE_05]
        .wdata       (SFR_WDATA),
        .rdata       (store_rdata),
        .offset_coef (store_offset),
        .gain_coef   (store_gain)
    );

    // Flipping the sign bit turns a signed order into an unsigned one
    always_comb begin
        if (DIFF_MODE) begin
            res_key   = {~CONV0_RESULT[15], CONV0_RESULT[14:0]}; // [RULE_15] [RULE_11]
            lower_key = {~st.lower_limit[15], st.lower_limit[14:0]}; // [RULE_15]
            upper_key = {~st.upper_limit[15], st.upper_limit[14:0]}; // [RULE_15]
        end else begin
            res_key   = CONV0_RESULT; // [RULE_11]
            lower_key = st.lower_limit;
            upper_key = st.upper_limit;
        end
    end

    assign below_lower = (res_key < lower_key);
    assign above_upper = (res_key > upper_key);
    assign inside_mode = (lower_key > upper_key); // [RULE_12]

    always_comb begin
        if (inside_mode) begin
            window_hit = below_lower && above_upper; // [RULE_13]
        end else begin
            window_hit = below_lower || above_upper; // [RULE_14]
        end
    end

    // One trim path per converter
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_trim
            // Offset shift positive for codes below neutral; slope shift positive for codes above
            assign trim_offset[c] = acw_pkg::OFFSET_NEUTRAL - store_offset[c]; // [RULE_01]
            assign trim_slope[c]  = store_gain[c] - acw_pkg::GAIN_NEUTRAL; // [RULE_02]
        end
    endgenerate

    always_comb begin
        next_st = st;

        // Register writes
        if (SFR_WR) begin
            case (SFR_ADDR)
                acw_pkg::ADDR_CALIB_POINTER: begin
                    next_st.pointer_auto_advance         = SFR_WDATA[acw_pkg::PTR_ADVANCE_BIT];
                    next_st.converter_coeff_select       = SFR_WDATA[acw_pkg::PTR_SELECT_BIT]; // [RULE_04]
                    next_st.coefficient_location_pointer = SFR_WDATA[5:0]; // [RULE_05]
                end
                acw_pkg::ADDR_LOWER_LIMIT_HIGH: begin
                    next_st.lower_limit[15:8] = SFR_WDATA; // [RULE_10]
                end
                acw_pkg::ADDR_LOWER_LIMIT_LOW: begin
                    next_st.lower_limit[7:0] = SFR_WDATA; // [RULE_10]
                end
                acw_pkg::ADDR_UPPER_LIMIT_HIGH: begin
                    next_st.upper_limit[15:8] = SFR_WDATA; // [RULE_10]
                end
                acw_pkg::ADDR_UPPER_LIMIT_LOW: begin
                    next_st.upper_limit[7:0] = SFR_WDATA; // [RULE_10]
                end
                acw_pkg::ADDR_CONVERTER0_CONTROL: begin
                    next_st.window_compare_flag = SFR_WDATA[acw_pkg::CTRL_WINDOW_FLAG_BIT]; // [RULE_16]
                end
                default: begin
                end
            endcase
        end

        // Advance after the access, wrapping within the 6-bit field
        if (port_access && st.pointer_auto_advance) begin
            next_st.coefficient_location_pointer = st.coefficient_location_pointer + 6'h01; // [RULE_03]
        end

        // Hardware set wins over a software clear in the same cycle
        if (CONV0_DONE && window_hit) begin
            next_st.window_compare_flag = 1'b1; // [RULE_08] [RULE_16]
        end

        // Read data, registered; unmapped addresses read zero
        next_st.rdata = 8'h00;
        if (SFR_RD) begin
            case (SFR_ADDR)
                acw_pkg::ADDR_CALIB_POINTER: begin
                    next_st.rdata = {st.pointer_auto_advance, st.converter_coeff_select,
                                     st.coefficient_location_pointer};
                end
                acw_pkg::ADDR_CALIB_COEFFICIENT_PORT: begin
                    next_st.rdata = store_rdata; // [RULE_06]
                end
                acw_pkg::ADDR_LOWER_LIMIT_HIGH: begin
                    next_st.rdata = st.lower_limit[15:8];
                end
                acw_pkg::ADDR_LOWER_LIMIT_LOW: begin
                    next_st.rdata = st.lower_limit[7:0];
                end
                acw_pkg::ADDR_UPPER_LIMIT_HIGH: begin
                    next_st.rdata = st.upper_limit[15:8];
                end
                acw_pkg::ADDR_UPPER_LIMIT_LOW: begin
                    next_st.rdata = st.upper_limit[7:0];
                end
                acw_pkg::ADDR_CONVERTER0_CONTROL: begin
                    next_st.rdata[acw_pkg::CTRL_WINDOW_FLAG_BIT] = st.window_compare_flag; // [RULE_09]
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // Trim values follow the stored coefficients one cycle later
        next_st.offset_coef  = store_offset; // [RULE_01]
        next_st.gain_coef    = store_gain; // [RULE_02]
        next_st.offset_shift = trim_offset; // [RULE_01]
        next_st.slope_shift  = trim_slope; // [RULE_02]
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st.pointer_auto_advance         <= acw_pkg::PTR_RESET[acw_pkg::PTR_ADVANCE_BIT];
            st.converter_coeff_select       <= acw_pkg::PTR_RESET[acw_pkg::PTR_SELECT_BIT];
            st.coefficient_location_pointer <= acw_pkg::PTR_RESET[5:0];
            st.lower_limit                  <= acw_pkg::LIMIT_RESET;
            st.upper_limit                  <= acw_pkg::LIMIT_RESET;
            st.window_compare_flag          <= 1'b0;
            st.rdata                        <= 8'h00;
            st.offset_coef                  <= '0;
            st.gain_coef                    <= '0;
            st.offset_shift                 <= '0;
            st.slope_shift                  <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign SFR_RDATA     = st.rdata;
    assign WINDOW_FLAG   = st.window_compare_flag; // [RULE_09]
    assign WINDOW_IRQ    = st.window_compare_flag; // [RULE_09]
    assign OFFSET_COEF0  = st.offset_coef[0];
    assign OFFSET_COEF1  = st.offset_coef[1];
    assign GAIN_COEF0    = st.gain_coef[0];
    assign GAIN_COEF1    = st.gain_coef[1];
    assign OFFSET_SHIFT0 = st.offset_shift[0];
    assign OFFSET_SHIFT1 = st.offset_shift[1];
    assign SLOPE_SHIFT0  = st.slope_shift[0];
    assign SLOPE_SHIFT1  = st.slope_shift[1];
endmodule

/* verilog/acw_pkg.sv */
// Constants shared by the calibration access and window compare block
package acw_pkg;
    localparam int unsigned SFR_AW = 8;
    localparam int unsigned SFR_DW = 8;

    // Register addresses in the special function space
    localparam logic [7:0] ADDR_CALIB_POINTER          = 8'hba;
    localparam logic [7:0] ADDR_CALIB_COEFFICIENT_PORT = 8'hbb;
    localparam logic [7:0] ADDR_LOWER_LIMIT_HIGH       = 8'hc7;
    localparam logic [7:0] ADDR_LOWER_LIMIT_LOW        = 8'hc6;
    localparam logic [7:0] ADDR_UPPER_LIMIT_HIGH       = 8'hc5;
    localparam logic [7:0] ADDR_UPPER_LIMIT_LOW        = 8'hc4;
    localparam logic [7:0] ADDR_CONVERTER0_CONTROL     = 8'he8;

    // Pointer register layout and reset value
    localparam int unsigned PTR_ADVANCE_BIT = 7;
    localparam int unsigned PTR_SELECT_BIT  = 6;
    localparam int unsigned PTR_LOC_W       = 6;
    localparam logic [7:0]  PTR_RESET       = 8'hd7;

    // Control register layout
    localparam int unsigned CTRL_WINDOW_FLAG_BIT = 3;

    // Coefficient location map
    localparam logic [5:0] LOC_LINEARITY_LAST = 6'h12;
    localparam logic [5:0] LOC_OFFSET_LOW     = 6'h13;
    localparam logic [5:0] LOC_OFFSET_HIGH    = 6'h14;
    localparam logic [5:0] LOC_GAIN_LOW       = 6'h15;
    localparam logic [5:0] LOC_GAIN_HIGH      = 6'h16;
    localparam logic [7:0] OFFSET_HIGH_MASK   = 8'h3f;
    localparam logic [7:0] GAIN_HIGH_MASK     = 8'h1f;

    // Coefficient widths and neutral points
    localparam int unsigned OFFSET_W       = 14;
    localparam int unsigned GAIN_W         = 13;
    localparam logic [13:0] OFFSET_NEUTRAL = 14'h2000;
    localparam logic [12:0] GAIN_NEUTRAL   = 13'h1000;

    localparam int unsigned RESULT_W    = 16;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
endpackage

/* verilog/acw_coef_store.sv */
// Calibration coefficient storage for both converters
module acw_coef_store #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned BANKS = 2
) (
    input  wire logic                                   clk,
    input  wire logic                                   wr_en,
    input  wire logic                                   bank,
    input  wire logic [acw_pkg::PTR_LOC_W-1:0]          loc,
    input  wire logic [7:0]                             wdata,
    output logic      [7:0]                             rdata,
    output logic      [BANKS-1:0][acw_pkg::OFFSET_W-1:0] offset_coef,
    output logic      [BANKS-1:0][acw_pkg::GAIN_W-1:0]   gain_coef
);
    // No reset: the contents are variable after power-up
    logic [7:0] mem [BANKS][DEPTH];
    logic [7:0] wmask;

    always_comb begin
        if (loc == acw_pkg::LOC_OFFSET_HIGH) begin
            wmask = acw_pkg::OFFSET_HIGH_MASK;
        end else if (loc == acw_pkg::LOC_GAIN_HIGH) begin
            wmask = acw_pkg::GAIN_HIGH_MASK;
        end else begin
            wmask = 8'hff;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[bank][loc] <= wdata & wmask; // [RULE_06] [RULE_07]
        end
    end

    assign rdata = mem[bank][loc]; // [RULE_06]

    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            // Unused upper bits are masked on write, so they read as zero
            assign offset_coef[b] = {mem[b][acw_pkg::LOC_OFFSET_HIGH][5:0],
                                     mem[b][acw_pkg::LOC_OFFSET_LOW]}; // [RULE_01] [RULE_07]
            assign gain_coef[b]   = {mem[b][acw_pkg::LOC_GAIN_HIGH][4:0],
                                     mem[b][acw_pkg::LOC_GAIN_LOW]}; // [RULE_02] [RULE_07]
        end
    endgenerate
endmodule

/* bench/acw_chk.sv */
// Port-level assertions for the calibration access and window compare block
module acw_chk (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic [7:0]  SFR_RDATA,
    input  wire logic        CONV0_DONE,
    input  wire logic [15:0] CONV0_RESULT,
    input  wire logic        DIFF_MODE,
    input  wire logic        WINDOW_FLAG,
    input  wire logic        WINDOW_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [15:0] lo, up, kr, kl, ku;
    logic        hit, clr, clr_zero;
    logic [7:0]  lo_high;
    // Shadow limits, so the verdict is predicted from bus traffic alone
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lo <= 16'h0000;
            up <= 16'h0000;
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                acw_pkg::ADDR_LOWER_LIMIT_HIGH: lo[15:8] <= SFR_WDATA;
                acw_pkg::ADDR_LOWER_LIMIT_LOW:  lo[7:0] <= SFR_WDATA;
                acw_pkg::ADDR_UPPER_LIMIT_HIGH: up[15:8] <= SFR_WDATA;
                acw_pkg::ADDR_UPPER_LIMIT_LOW:  up[7:0] <= SFR_WDATA;
                default: ;
            endcase
        end
    end
    // Flipping the sign bit turns signed order into unsigned order
    assign kr = {CONV0_RESULT[15] ^ DIFF_MODE, CONV0_RESULT[14:0]};
    assign kl = {lo[15] ^ DIFF_MODE, lo[14:0]};
    assign ku = {up[15] ^ DIFF_MODE, up[14:0]};
    assign hit = (kl > ku) ? (kr < kl && kr > ku) : (kr > ku || kr < kl);
    assign clr = SFR_WR && SFR_ADDR == acw_pkg::ADDR_CONVERTER0_CONTROL;
    assign clr_zero = clr && !SFR_WDATA[acw_pkg::CTRL_WINDOW_FLAG_BIT];
    assign lo_high = lo[15:8];
    sequence s_hit;
        CONV0_DONE && hit;
    endsequence
    sequence s_ctrl_rd;
        SFR_RD && SFR_ADDR == acw_pkg::ADDR_CONVERTER0_CONTROL;
    endsequence
    sequence s_lth_rd;
        SFR_RD && SFR_ADDR == acw_pkg::ADDR_LOWER_LIMIT_HIGH;
    endsequence
    a_irq_mirrors_flag: assert property (WINDOW_IRQ == WINDOW_FLAG)
        else $error("irq differs from flag");
    a_hit_sets_flag: assert property (s_hit |=> WINDOW_FLAG)
        else $error("hit did not set flag");
    a_miss_keeps_flag: assert property (!WINDOW_FLAG && !clr && !(CONV0_DONE && hit) |=> !WINDOW_FLAG)
        else $error("flag set without hit");
    a_flag_stays_set: assert property (WINDOW_FLAG && !clr |=> WINDOW_FLAG)
        else $error("flag dropped on its own");
    a_flag_sw_clear: assert property (clr_zero && !(CONV0_DONE && hit) |=> !WINDOW_FLAG)
        else $error("flag not cleared");
    a_idle_read_zero: assert property (!SFR_RD |=> SFR_RDATA == 8'h00)
        else $error("read data not idle");
    a_ctrl_read_flag: assert property (s_ctrl_rd |=> SFR_RDATA == {4'h0, $past(WINDOW_FLAG), 3'h0})
        else $error("control read wrong");
    a_limit_read_back: assert property (s_lth_rd |=> SFR_RDATA == $past(lo_high))
        else $error("limit read wrong");
endmodule

/* bench/adc_calib_access_window_compare_tb_top.sv */
// Directed bench for the calibration access and window compare block
module adc_calib_access_window_compare_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, done = 1'b0, diff = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] result = 16'h0000;
    logic        flag, irq;
    logic [13:0] oc0, oc1, os0, os1;
    logic [12:0] gc0, gc1, ss0, ss1;
    int          fail_count = 0;
    int          comparisons = 0;
    localparam logic [7:0] PT = acw_pkg::ADDR_CALIB_POINTER, CP = acw_pkg::ADDR_CALIB_COEFFICIENT_PORT;
    localparam logic [7:0] CT = acw_pkg::ADDR_CONVERTER0_CONTROL;
    acw_top uut (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .CONV0_DONE(done), .CONV0_RESULT(result),
        .DIFF_MODE(diff), .WINDOW_FLAG(flag), .WINDOW_IRQ(irq), .OFFSET_COEF0(oc0),
        .OFFSET_COEF1(oc1), .GAIN_COEF0(gc0), .GAIN_COEF1(gc1), .OFFSET_SHIFT0(os0),
        .OFFSET_SHIFT1(os1), .SLOPE_SHIFT0(ss0), .SLOPE_SHIFT1(ss1));
    always #20 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk("read data", {8'h00, e}, {8'h00, rdata});
    endtask
    // Flag cleared first so each result is judged on its own
    task automatic conv(input logic [15:0] r, input logic e);
        wr(CT, 8'h00);
        @(negedge clk);
        result = r;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("window flag", {15'h0000, e}, {15'h0000, flag});
    endtask
    task automatic win(input logic [15:0] lo, input logic [15:0] up, input logic d, input logic [63:0] rs);
        wr(8'hc7, lo[15:8]);
        wr(8'hc6, lo[7:0]);
        wr(8'hc5, up[15:8]);
        wr(8'hc4, up[7:0]);
        diff = d;
        for (int i = 0; i < 4; i++) conv(rs[16*i +: 16], i < 2);
    endtask
    task automatic test_reset;
        rd(PT, 8'hd7);
        rd(8'hc7, 8'h00);
        rd(CT, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        $display("test reset done");
    endtask
    task automatic test_coef;
        wr(PT, 8'h93);
        wr(CP, 8'h34);
        wr(CP, 8'h12);
        wr(CP, 8'h00);
        wr(CP, 8'h10);
        rd(PT, 8'h97);
        wr(PT, 8'hd3);
        for (int i = 0; i < 4; i++) wr(CP, 8'hff);
        @(negedge clk);
        chk("offset0", 16'h1234, {2'b00, oc0});
        chk("oshift0", 16'h0dcc, {2'b00, os0});
        chk("gain0", 16'h1000, {3'b000, gc0});
        chk("sshift0", 16'h0000, {3'b000, ss0});
        chk("offset1", 16'h3fff, {2'b00, oc1});
        chk("oshift1", 16'h2001, {2'b00, os1});
        chk("gain1", 16'h1fff, {3'b000, gc1});
        chk("sshift1", 16'h0fff, {3'b000, ss1});
        wr(PT, 8'h13);
        rd(CP, 8'h34);
        rd(CP, 8'h34);
        wr(PT, 8'h94);
        rd(CP, 8'h12);
        rd(CP, 8'h00);
        rd(PT, 8'h96);
        wr(PT, 8'h54);
        rd(CP, 8'h3f);
        wr(PT, 8'hbf);
        wr(CP, 8'ha5);
        rd(PT, 8'h80);
        wr(PT, 8'h3f);
        rd(CP, 8'ha5);
        $display("test coefficients done");
    endtask
    task automatic test_window;
        win(16'h2000, 16'h1000, 1'b0, 64'h1000_2000_1fff_1001);
        win(16'h1000, 16'h2000, 1'b0, 64'h1800_2000_0fff_2001);
        win(16'h1000, 16'hffff, 1'b1, 64'h1000_8000_0fff_0000);
        win(16'hffff, 16'h1000, 1'b1, 64'h0000_ffff_1001_fffe);
        conv(16'hfffe, 1'b1);
        @(negedge clk);
        result = 16'h0000;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("sticky flag", 16'h0001, {15'h0000, flag});
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(CT, 8'h08);
        wr(CT, 8'h00);
        chk("cleared flag", 16'h0000, {15'h0000, flag});
        // Hit and software clear in one cycle: the hit must win
        @(negedge clk);
        addr = CT;
        wdata = 8'h00;
        sfr_wr = 1'b1;
        result = 16'hfffe;
        done = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        done = 1'b0;
        chk("set over clear", 16'h0001, {15'h0000, flag});
        rd(8'hc6, 8'hff);
        rd(8'hc5, 8'h10);
        rd(8'hc4, 8'h00);
        $display("test window done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_coef();
        test_window();
        end_of_test();
    end
    // About 180 cycles expected; generous margin
    initial begin
        #200us;
        fail_count++;
        end_of_test();
    end
endmodule
bind acw_top acw_chk chk_i (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CONV0_DONE(CONV0_DONE), .CONV0_RESULT(CONV0_RESULT),
    .DIFF_MODE(DIFF_MODE), .WINDOW_FLAG(WINDOW_FLAG), .WINDOW_IRQ(WINDOW_IRQ));
